// *** hdl/dpc_pkg.sv ***
// Package for the PLL configuration and averaged calibration register bank.
// Assumes byte-wide registers reached through the device serial control port.
package dpc_pkg;
	localparam logic [11:0] ADDR_LOOP_FILTER_CTRL3 = 12'h089;
	localparam logic [11:0] ADDR_CHARGE_PUMP_CTRL = 12'h08a;
	localparam logic [11:0] ADDR_VCO_DIVIDER_CTRL = 12'h08b;
	localparam logic [11:0] ADDR_REF_DIVIDER_CTRL = 12'h08c;
	localparam logic [11:0] ADDR_PLL_REGULATOR_CTRL = 12'h08d;
	localparam logic [11:0] ADDR_GLOBAL_CALIBRATION_CTRL = 12'h0e2;
	localparam int BIT_RES3_BYPASS = 7;
	localparam int BIT_RES1_BYPASS = 6;
	localparam int BIT_CAP2_BYPASS = 5;
	localparam int BIT_CAP1_BYPASS = 4;
	localparam int BIT_CAL_TRIGGER = 1;
	localparam int BIT_CAL_ENABLE = 0;
	localparam logic [3:0] RST_LOOP_RES3_SETTING = 4'h8;
	localparam logic [3:0] RST_LOOP_BYPASS = 4'h0;
	localparam logic [5:0] RST_PUMP_CURRENT = 6'h20;
	localparam logic [1:0] RST_VCO_POST_DIV = 2'h2;
	localparam logic [2:0] RST_REF_PRE_DIV = 3'h1;
	localparam logic [7:0] RST_PLL_REGULATOR = 8'h2b;
	localparam logic [1:0] RST_CAL_CTRL = 2'h0;
	localparam logic [2:0] REF_DIV_MAX_CODE = 3'h4;
endpackage

// *** hdl/dpc_edge_detect.sv ***
// Rising edge detector for a register bit in the control port clock domain.
// Assumes the input is already synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module dpc_edge_detect (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic level_i,
	output logic rise_o
);
	typedef struct packed {
		logic last;
	} dpc_edge_state_type;
	dpc_edge_state_type s_q;
	dpc_edge_state_type s_d;
	always_comb begin
		s_d = s_q;
		s_d.last = level_i;
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign rise_o = level_i & ~s_q.last;
endmodule
`default_nettype wire

// *** hdl/dpc_regs.sv ***
// Register bank for the converter clock multiplier PLL and the averaged calibration control.
// Assumes a byte-wide write/read port from the serial control port decoder in the same clock domain.
// Functional notes
// - A set bypass bit with zero component word removes that component entirely.
// - Third resistor word sits in bits 3..0, resets 0x8, best at 0xE.
// - Charge pump current is bits 5..0, resets 0x20, best at 0x12.
// - Post divider codes 01, 10, 11 give divide by 4, 8, 16; reset 0x2.
// - Pre divider codes 000 to 100 give divide by 1, 2, 4, 8, 16; reset 0x1.
// - Regulator setting is eight bits, resets 0x2B, software writes 0x7B.
// - A rising edge of the averaged trigger launches calibration of all converters.
// - Enable is set before the trigger; while set, calibration runs and results apply.
`timescale 1ns/1ps
`default_nettype none
module dpc_regs (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic wr_en_i,
	input wire logic [11:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [3:0] loop_res1_word_i,
	input wire logic [3:0] loop_cap2_word_i,
	input wire logic [3:0] loop_cap1_word_i,
	output logic [7:0] rdata_o,
	output logic [3:0] loop_bypass_o,
	output logic [3:0] loop_res3_setting_o,
	output logic [5:0] pump_current_setting_o,
	output logic [4:0] vco_post_divide_ratio_o,
	output logic [4:0] ref_pre_divide_ratio_o,
	output logic [7:0] pll_regulator_setting_o,
	output logic averaged_cal_start_o,
	output logic averaged_cal_apply_o
);
	typedef struct packed {
		logic [3:0] loop_bypass;
		logic [3:0] loop_res3_setting;
		logic [5:0] pump_current_setting;
		logic [1:0] vco_post_divider_select;
		logic [2:0] ref_pre_divider_select;
		logic [7:0] pll_regulator_setting;
		logic averaged_cal_trigger;
		logic averaged_cal_enable;
		logic [7:0] rdata;
		logic [4:0] vco_ratio;
		logic [4:0] ref_ratio;
		logic [3:0] bypass_eff;
	} dpc_regs_state_type;
	dpc_regs_state_type s_q;
	dpc_regs_state_type s_d;
	logic trig_rise;

	dpc_edge_detect u_trig_edge (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.level_i(s_q.averaged_cal_trigger),
		.rise_o(trig_rise)
	);

	always_comb begin
		s_d = s_q;
		if (wr_en_i) begin
			unique case (addr_i)
				dpc_pkg::ADDR_LOOP_FILTER_CTRL3: begin
					s_d.loop_bypass = wdata_i[7:4];
					s_d.loop_res3_setting = wdata_i[3:0];
				end
				dpc_pkg::ADDR_CHARGE_PUMP_CTRL: begin
					s_d.pump_current_setting = wdata_i[5:0];
				end
				dpc_pkg::ADDR_VCO_DIVIDER_CTRL: begin
					s_d.vco_post_divider_select = wdata_i[1:0];
				end
				dpc_pkg::ADDR_REF_DIVIDER_CTRL: begin
					s_d.ref_pre_divider_select = wdata_i[2:0];
				end
				dpc_pkg::ADDR_PLL_REGULATOR_CTRL: begin
					s_d.pll_regulator_setting = wdata_i;
				end
				dpc_pkg::ADDR_GLOBAL_CALIBRATION_CTRL: begin
					s_d.averaged_cal_trigger = wdata_i[dpc_pkg::BIT_CAL_TRIGGER];
					s_d.averaged_cal_enable = wdata_i[dpc_pkg::BIT_CAL_ENABLE];
				end
				default: begin
				end
			endcase
		end
		// Read data is registered; unmapped and reserved bits read zero.
		unique case (addr_i)
			dpc_pkg::ADDR_LOOP_FILTER_CTRL3: s_d.rdata = {s_q.loop_bypass, s_q.loop_res3_setting};
			dpc_pkg::ADDR_CHARGE_PUMP_CTRL: s_d.rdata = {2'h0, s_q.pump_current_setting};
			dpc_pkg::ADDR_VCO_DIVIDER_CTRL: s_d.rdata = {6'h00, s_q.vco_post_divider_select};
			dpc_pkg::ADDR_REF_DIVIDER_CTRL: s_d.rdata = {5'h00, s_q.ref_pre_divider_select};
			dpc_pkg::ADDR_PLL_REGULATOR_CTRL: s_d.rdata = s_q.pll_regulator_setting;
			dpc_pkg::ADDR_GLOBAL_CALIBRATION_CTRL: s_d.rdata = {6'h00, s_q.averaged_cal_trigger,
				s_q.averaged_cal_enable};
			default: s_d.rdata = 8'h00;
		endcase
		// Code 00 is undocumented for the post divider; it is held at the reset ratio of 8.
		unique case (s_q.vco_post_divider_select)
			2'h1: s_d.vco_ratio = 5'h04;
			2'h2: s_d.vco_ratio = 5'h08;
			2'h3: s_d.vco_ratio = 5'h10;
			default: s_d.vco_ratio = 5'h08;
		endcase
		// Codes above 100 have no ratio; they clamp to divide by 16 to keep the reference low.
		if (s_q.ref_pre_divider_select > dpc_pkg::REF_DIV_MAX_CODE) begin
			s_d.ref_ratio = 5'h10;
		end else begin
			s_d.ref_ratio = 5'(5'h01 << s_q.ref_pre_divider_select);
		end
		// A bypass only acts when its component word is zero, so the loop-filter words enter here.
		s_d.bypass_eff[3] = s_q.loop_bypass[3] & (s_q.loop_res3_setting == 4'h0);
		s_d.bypass_eff[2] = s_q.loop_bypass[2] & (loop_res1_word_i == 4'h0);
		s_d.bypass_eff[1] = s_q.loop_bypass[1] & (loop_cap2_word_i == 4'h0);
		s_d.bypass_eff[0] = s_q.loop_bypass[0] & (loop_cap1_word_i == 4'h0);
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_q.loop_bypass <= dpc_pkg::RST_LOOP_BYPASS;
			s_q.loop_res3_setting <= dpc_pkg::RST_LOOP_RES3_SETTING;
			s_q.pump_current_setting <= dpc_pkg::RST_PUMP_CURRENT;
			s_q.vco_post_divider_select <= dpc_pkg::RST_VCO_POST_DIV;
			s_q.ref_pre_divider_select <= dpc_pkg::RST_REF_PRE_DIV;
			s_q.pll_regulator_setting <= dpc_pkg::RST_PLL_REGULATOR;
			s_q.averaged_cal_trigger <= dpc_pkg::RST_CAL_CTRL[dpc_pkg::BIT_CAL_TRIGGER];
			s_q.averaged_cal_enable <= dpc_pkg::RST_CAL_CTRL[dpc_pkg::BIT_CAL_ENABLE];
			s_q.rdata <= 8'h00;
			s_q.vco_ratio <= 5'h08;
			s_q.ref_ratio <= 5'h02;
			s_q.bypass_eff <= 4'h0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata_o = s_q.rdata;
	assign loop_bypass_o = s_q.bypass_eff;
	assign loop_res3_setting_o = s_q.loop_res3_setting;
	assign pump_current_setting_o = s_q.pump_current_setting;
	assign vco_post_divide_ratio_o = s_q.vco_ratio;
	assign ref_pre_divide_ratio_o = s_q.ref_ratio;
	assign pll_regulator_setting_o = s_q.pll_regulator_setting;
	// Start is one cycle wide; a held one produces no further start.
	assign averaged_cal_start_o = trig_rise & s_q.averaged_cal_enable;
	assign averaged_cal_apply_o = s_q.averaged_cal_enable;

	property p_start_needs_edge;
		@(posedge clk_i) disable iff (!rst_n_i)
			averaged_cal_start_o |-> s_q.averaged_cal_trigger && !$past(s_q.averaged_cal_trigger);
	endproperty
	a_start_needs_edge: assert property (p_start_needs_edge) else $error("start without trigger edge");

	property p_write_one_starts;
		@(posedge clk_i) disable iff (!rst_n_i)
			(wr_en_i && addr_i == dpc_pkg::ADDR_GLOBAL_CALIBRATION_CTRL && wdata_i[1:0] == 2'h3
			&& !s_q.averaged_cal_trigger && s_q.averaged_cal_enable) |=> averaged_cal_start_o;
	endproperty
	a_write_one_starts: assert property (p_write_one_starts) else $error("trigger edge missed");

	property p_start_single;
		@(posedge clk_i) disable iff (!rst_n_i)
			averaged_cal_start_o |=> !averaged_cal_start_o;
	endproperty
	a_start_single: assert property (p_start_single) else $error("start longer than one cycle");

	property p_start_enabled;
		@(posedge clk_i) disable iff (!rst_n_i)
			averaged_cal_start_o |-> averaged_cal_apply_o;
	endproperty
	a_start_enabled: assert property (p_start_enabled) else $error("start while disabled");

	property p_vco_ratio;
		@(posedge clk_i) disable iff (!rst_n_i)
			(s_q.vco_post_divider_select == 2'h3) ##1 (s_q.vco_post_divider_select == 2'h3)
			|-> vco_post_divide_ratio_o == 5'h10;
	endproperty
	a_vco_ratio: assert property (p_vco_ratio) else $error("post divide ratio wrong");

	property p_ref_ratio;
		@(posedge clk_i) disable iff (!rst_n_i)
			(s_q.ref_pre_divider_select == 3'h4) ##1 (s_q.ref_pre_divider_select == 3'h4)
			|-> ref_pre_divide_ratio_o == 5'h10;
	endproperty
	a_ref_ratio: assert property (p_ref_ratio) else $error("pre divide ratio wrong");

	property p_reserved_zero;
		@(posedge clk_i) disable iff (!rst_n_i)
			(addr_i == dpc_pkg::ADDR_CHARGE_PUMP_CTRL) |=> rdata_o[7:6] == 2'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

	property p_bypass_word;
		@(posedge clk_i) disable iff (!rst_n_i)
			loop_bypass_o[3] |-> $past(s_q.loop_res3_setting) == 4'h0;
	endproperty
	a_bypass_word: assert property (p_bypass_word) else $error("bypass with nonzero word");

	property p_pump_write;
		@(posedge clk_i) disable iff (!rst_n_i)
			(wr_en_i && addr_i == dpc_pkg::ADDR_CHARGE_PUMP_CTRL) |=> pump_current_setting_o == $past(wdata_i[5:0]);
	endproperty
	a_pump_write: assert property (p_pump_write) else $error("pump current not stored");

	// The neighbouring words arrive from outside the bank, so each gate is checked both ways.
	property p_bypass_res1;
		@(posedge clk_i) disable iff (!rst_n_i)
			loop_bypass_o[2] == ($past(s_q.loop_bypass[2]) && ($past(loop_res1_word_i) == 4'h0));
	endproperty
	a_bypass_res1: assert property (p_bypass_res1) else $error("res1 bypass gating wrong");

	property p_bypass_cap2;
		@(posedge clk_i) disable iff (!rst_n_i)
			loop_bypass_o[1] == ($past(s_q.loop_bypass[1]) && ($past(loop_cap2_word_i) == 4'h0));
	endproperty
	a_bypass_cap2: assert property (p_bypass_cap2) else $error("cap2 bypass gating wrong");

	property p_bypass_cap1;
		@(posedge clk_i) disable iff (!rst_n_i)
			loop_bypass_o[0] == ($past(s_q.loop_bypass[0]) && ($past(loop_cap1_word_i) == 4'h0));
	endproperty
	a_bypass_cap1: assert property (p_bypass_cap1) else $error("cap1 bypass gating wrong");
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the PLL configuration and averaged calibration register bank.
// Assumes the bank answers reads one cycle after the address and takes writes on a one-cycle strobe.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_i, rst_n_i, wr_en_i;
	logic [11:0] addr_i;
	logic [7:0] wdata_i, rdata_o, pll_regulator_setting_o;
	logic [3:0] loop_bypass_o, loop_res3_setting_o;
	logic [3:0] loop_res1_word_i, loop_cap2_word_i, loop_cap1_word_i;
	logic [5:0] pump_current_setting_o;
	logic [4:0] vco_post_divide_ratio_o, ref_pre_divide_ratio_o;
	logic averaged_cal_start_o, averaged_cal_apply_o;
	int n_mismatch, compares, n_start;
	logic [11:0] adr [5] = '{dpc_pkg::ADDR_LOOP_FILTER_CTRL3, dpc_pkg::ADDR_CHARGE_PUMP_CTRL,
		dpc_pkg::ADDR_VCO_DIVIDER_CTRL, dpc_pkg::ADDR_REF_DIVIDER_CTRL, dpc_pkg::ADDR_PLL_REGULATOR_CTRL};
	logic [7:0] rst_val [5] = '{8'h08, 8'h20, 8'h02, 8'h01, 8'h2b};
	logic [7:0] wmask [5] = '{8'hff, 8'h3f, 8'h03, 8'h07, 8'hff};
	logic [4:0] ref_ratio [8] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h10, 5'h10, 5'h10};
	logic [4:0] vco_ratio [4] = '{5'h08, 5'h04, 5'h08, 5'h10};
	dpc_regs dpc_regs_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .loop_res1_word_i(loop_res1_word_i), .loop_cap2_word_i(loop_cap2_word_i),
		.loop_cap1_word_i(loop_cap1_word_i), .rdata_o(rdata_o), .loop_bypass_o(loop_bypass_o),
		.loop_res3_setting_o(loop_res3_setting_o), .pump_current_setting_o(pump_current_setting_o),
		.vco_post_divide_ratio_o(vco_post_divide_ratio_o), .ref_pre_divide_ratio_o(ref_pre_divide_ratio_o),
		.pll_regulator_setting_o(pll_regulator_setting_o), .averaged_cal_start_o(averaged_cal_start_o),
		.averaged_cal_apply_o(averaged_cal_apply_o));
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	// Counting pulses catches both a missing start and one that lasts too long.
	always @(posedge clk_i) begin
		if (averaged_cal_start_o === 1'b1) n_start++;
	end
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_i);
		#1;
		wr_en_i = 1'b1;
		addr_i = a;
		wdata_i = d;
		@(posedge clk_i);
		#1;
		wr_en_i = 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		#1;
		addr_i = a;
		@(posedge clk_i);
		#1;
		check($sformatf("rdata at %h", a), exp, rdata_o);
	endtask
	task automatic do_reset;
		@(posedge clk_i);
		#1;
		rst_n_i = 1'b0;
		repeat (3) @(posedge clk_i);
		#1;
		rst_n_i = 1'b1;
	endtask
	task automatic check_reset;
		for (int i = 0; i < 5; i++) rd(adr[i], rst_val[i]);
		rd(dpc_pkg::ADDR_GLOBAL_CALIBRATION_CTRL, 8'h00);
		rd(12'h0e3, 8'h00);
		check("bypass", 8'h00, {4'h0, loop_bypass_o});
		check("res3", 8'h08, {4'h0, loop_res3_setting_o});
		check("pump", 8'h20, {2'h0, pump_current_setting_o});
		check("vco ratio", 8'h08, {3'h0, vco_post_divide_ratio_o});
		check("ref ratio", 8'h02, {3'h0, ref_pre_divide_ratio_o});
		check("regulator", 8'h2b, pll_regulator_setting_o);
		check("apply", 8'h00, {7'h0, averaged_cal_apply_o});
		$display("test reset values done");
	endtask
	task automatic cal_step(input logic [7:0] d, input int starts);
		wr(dpc_pkg::ADDR_GLOBAL_CALIBRATION_CTRL, d);
		rd(dpc_pkg::ADDR_GLOBAL_CALIBRATION_CTRL, d & 8'h03);
		check("apply", {7'h0, d[0]}, {7'h0, averaged_cal_apply_o});
		check("start pulses", 8'(starts), 8'(n_start));
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#(20000 * 5);
		n_mismatch++;
		test_done();
	end
	initial begin
		rst_n_i = 1'b0;
		wr_en_i = 1'b0;
		addr_i = 12'h000;
		wdata_i = 8'h00;
		loop_res1_word_i = 4'h8;
		loop_cap2_word_i = 4'h8;
		loop_cap1_word_i = 4'h8;
		repeat (3) @(posedge clk_i);
		#1;
		rst_n_i = 1'b1;
		check_reset();
		for (int i = 0; i < 5; i++) begin
			wr(adr[i], 8'hff);
			rd(adr[i], wmask[i]);
			wr(adr[i], 8'h00);
			rd(adr[i], 8'h00);
		end
		wr(12'h0e3, 8'hff);
		rd(12'h0e3, 8'h00);
		$display("test access and reserved bits done");
		wr(dpc_pkg::ADDR_LOOP_FILTER_CTRL3, 8'h8e);
		rd(dpc_pkg::ADDR_LOOP_FILTER_CTRL3, 8'h8e);
		check("res3 bypass", 8'h00, {7'h0, loop_bypass_o[3]});
		check("res3", 8'h0e, {4'h0, loop_res3_setting_o});
		wr(dpc_pkg::ADDR_LOOP_FILTER_CTRL3, 8'h80);
		rd(dpc_pkg::ADDR_LOOP_FILTER_CTRL3, 8'h80);
		check("res3 bypass", 8'h01, {7'h0, loop_bypass_o[3]});
		// The other three words live outside this bank, so their bypasses wait on the word inputs.
		@(posedge clk_i);
		#1;
		loop_res1_word_i = 4'h0;
		loop_cap1_word_i = 4'h0;
		wr(dpc_pkg::ADDR_LOOP_FILTER_CTRL3, 8'hf0);
		rd(dpc_pkg::ADDR_LOOP_FILTER_CTRL3, 8'hf0);
		check("bypass", 8'h0d, {4'h0, loop_bypass_o});
		@(posedge clk_i);
		#1;
		loop_cap2_word_i = 4'h0;
		rd(dpc_pkg::ADDR_LOOP_FILTER_CTRL3, 8'hf0);
		check("bypass", 8'h0f, {4'h0, loop_bypass_o});
		wr(dpc_pkg::ADDR_LOOP_FILTER_CTRL3, 8'h0e);
		rd(dpc_pkg::ADDR_LOOP_FILTER_CTRL3, 8'h0e);
		check("bypass", 8'h00, {4'h0, loop_bypass_o});
		wr(dpc_pkg::ADDR_CHARGE_PUMP_CTRL, 8'h12);
		wr(dpc_pkg::ADDR_PLL_REGULATOR_CTRL, 8'h7b);
		rd(dpc_pkg::ADDR_PLL_REGULATOR_CTRL, 8'h7b);
		check("pump", 8'h12, {2'h0, pump_current_setting_o});
		check("regulator", 8'h7b, pll_regulator_setting_o);
		for (int c = 0; c < 8; c++) begin
			wr(dpc_pkg::ADDR_REF_DIVIDER_CTRL, 8'(c));
			wr(dpc_pkg::ADDR_VCO_DIVIDER_CTRL, 8'(c % 4));
			rd(dpc_pkg::ADDR_VCO_DIVIDER_CTRL, 8'(c % 4));
			check("ref ratio", {3'h0, ref_ratio[c]}, {3'h0, ref_pre_divide_ratio_o});
			check("vco ratio", {3'h0, vco_ratio[c % 4]}, {3'h0, vco_post_divide_ratio_o});
		end
		// A 200 MHz input over 4 gives a 50 MHz reference; 1.2 GHz times 8 puts the VCO at 9.6 GHz.
		wr(dpc_pkg::ADDR_REF_DIVIDER_CTRL, 8'h02);
		wr(dpc_pkg::ADDR_VCO_DIVIDER_CTRL, 8'h02);
		rd(dpc_pkg::ADDR_REF_DIVIDER_CTRL, 8'h02);
		check("ref ratio", 8'h04, {3'h0, ref_pre_divide_ratio_o});
		check("vco ratio", 8'h08, {3'h0, vco_post_divide_ratio_o});
		$display("test field values done");
		// Trigger without enable must not launch; enable and trigger in one write does.
		cal_step(8'h02, 0);
		cal_step(8'h00, 0);
		cal_step(8'h01, 0);
		cal_step(8'h03, 1);
		cal_step(8'h03, 1);
		cal_step(8'h01, 1);
		cal_step(8'h03, 2);
		cal_step(8'h00, 2);
		cal_step(8'h03, 3);
		$display("test calibration trigger done");
		do_reset();
		check_reset();
		test_done();
	end
endmodule
`default_nettype wire
